// file: design/psc_ctrl.sv
// Power-saving state and machine-cycle rate controller with APB registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_ctrl #(
	parameter int WAKE_LOW_CYCLES = `PSC_WAKE_LOW_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic ext_int_n_i,
	input wire logic irq_pending_i,
	input wire logic irq_service_start_i,
	output logic fetch_en_o,
	output logic clk_run_o,
	output logic osc_restart_o,
	output logic cycle_en_o,
	output logic addr_latch_strobe_o,
	output logic program_store_strobe_o,
	output logic resume_o
);
	logic ext_int_lvl;
	logic cyc_en;
	psc_pkg::psc_state_t state_q;
	psc_pkg::psc_state_t state_d;
	logic idle_request_bit_q;
	logic powerdown_request_bit_q;
	logic double_clock_flag_q;
	logic security_flag_q;
	logic wake_en_q;
	logic wake_level_q;
	logic [10:0] low_cnt_q;
	logic low_done;
	logic acc_wr;
	logic acc_rd;
	logic addr_ok;
	logic [31:0] rd_mux;
	logic pc_wr;
	logic prog_wr;
	logic [11:0] reg_idx;

	psc_sync #(
		.RESET_VAL(1'b1)
	) u_int_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(ext_int_n_i),
		.level_o(ext_int_lvl)
	);

	psc_cycle_div u_div (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(state_q != psc_pkg::PSC_PDOWN),
		.double_i(double_clock_flag_q),
		.cycle_en_o(cyc_en)
	);

	// APB decode; one wait state, pready raised on the first access edge
	// Unaligned addresses fall on an unmapped index
	assign reg_idx = (paddr_i[1:0] == 2'b00) ? {2'b00, paddr_i[11:2]} : 12'hFFF;
	assign acc_wr = psel_i && penable_i && pwrite_i && !pready_o;
	assign acc_rd = psel_i && penable_i && !pwrite_i && !pready_o;
	assign addr_ok = (reg_idx == `PSC_OFS_FLASH_STATUS) || (reg_idx == `PSC_OFS_POWER_CTRL) ||
		(reg_idx == `PSC_OFS_WAKE_CFG) || (reg_idx == `PSC_OFS_MODE_STAT) ||
		(reg_idx == `PSC_OFS_PROG_CTRL);
	assign pc_wr = acc_wr && (reg_idx == `PSC_OFS_POWER_CTRL) && (state_q == psc_pkg::PSC_RUN);
	// Doubling needs the programming key; flash status itself is read-only
	assign prog_wr = acc_wr && (reg_idx == `PSC_OFS_PROG_CTRL) &&
		(pwdata_i[15:8] == `PSC_PROG_KEY);
	assign low_done = (low_cnt_q == 11'(WAKE_LOW_CYCLES));

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_idx)
			`PSC_OFS_FLASH_STATUS: begin
				rd_mux[`PSC_BIT_DOUBLE] = double_clock_flag_q;
				rd_mux[`PSC_BIT_SECURITY] = security_flag_q;
			end
			`PSC_OFS_POWER_CTRL: begin
				rd_mux[`PSC_BIT_IDLE] = idle_request_bit_q;
				rd_mux[`PSC_BIT_PDOWN] = powerdown_request_bit_q;
			end
			`PSC_OFS_WAKE_CFG: begin
				rd_mux[0] = wake_en_q;
				rd_mux[1] = wake_level_q;
			end
			`PSC_OFS_MODE_STAT: begin
				rd_mux[3:0] = state_q;
				rd_mux[4] = ext_int_lvl;
				rd_mux[15:5] = low_cnt_q;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= psel_i && penable_i && !pready_o;
			pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
			if (acc_rd) begin
				prdata_o <= rd_mux;
			end
		end
	end

	// Wake configuration: enable and level-sensitive select
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wake_en_q <= 1'b0;
			wake_level_q <= 1'b0;
		end else if (acc_wr && reg_idx == `PSC_OFS_WAKE_CFG) begin
			wake_en_q <= pwdata_i[0];
			wake_level_q <= pwdata_i[1];
		end
	end

	// Programming-path flags survive low-power states; only reset or a keyed write clears
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			double_clock_flag_q <= 1'b0;
			security_flag_q <= 1'b0;
		end else if (prog_wr) begin
			double_clock_flag_q <= pwdata_i[`PSC_BIT_DOUBLE];
			security_flag_q <= pwdata_i[`PSC_BIT_SECURITY];
		end
	end

	// Request bits; service start clears them, set wins in same cycle
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			idle_request_bit_q <= 1'b0;
			powerdown_request_bit_q <= 1'b0;
		end else if (pc_wr) begin
			// Both set at once is treated as power-down
			powerdown_request_bit_q <= pwdata_i[`PSC_BIT_PDOWN];
			idle_request_bit_q <= pwdata_i[`PSC_BIT_IDLE] && !pwdata_i[`PSC_BIT_PDOWN];
		end else if (irq_service_start_i && state_q == psc_pkg::PSC_IDLE) begin
			idle_request_bit_q <= 1'b0;
		end else if (irq_service_start_i && state_q == psc_pkg::PSC_WAKE) begin
			powerdown_request_bit_q <= 1'b0;
		end
	end

	// Wake-pin low-time counter, runs on the restarted oscillator
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			low_cnt_q <= 11'h000;
		end else if (state_q == psc_pkg::PSC_PDOWN && !ext_int_lvl && wake_en_q && wake_level_q) begin
			if (!low_done) begin
				low_cnt_q <= low_cnt_q + 11'h001;
			end
		end else if (state_q != psc_pkg::PSC_PDOWN) begin
			low_cnt_q <= 11'h000;
		end else if (!low_done) begin
			// Pin rose too early: start over
			low_cnt_q <= 11'h000;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			psc_pkg::PSC_RUN: begin
				if (pc_wr && pwdata_i[`PSC_BIT_PDOWN]) begin
					state_d = psc_pkg::PSC_PDOWN;
				end else if (pc_wr && pwdata_i[`PSC_BIT_IDLE]) begin
					state_d = psc_pkg::PSC_IDLE;
				end
			end
			psc_pkg::PSC_IDLE: begin
				if (irq_service_start_i) begin
					state_d = psc_pkg::PSC_RUN;
				end
			end
			psc_pkg::PSC_PDOWN: begin
				// Only an enabled level-sensitive pin held long enough wakes
				if (low_done && ext_int_lvl) begin
					state_d = psc_pkg::PSC_WAKE;
				end
			end
			psc_pkg::PSC_WAKE: begin
				if (irq_service_start_i) begin
					state_d = psc_pkg::PSC_RUN;
				end
			end
			default: begin
				state_d = psc_pkg::PSC_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_q <= psc_pkg::PSC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Sequencing outputs, all registered from next state
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			fetch_en_o <= 1'b1;
			clk_run_o <= 1'b1;
			osc_restart_o <= 1'b0;
			addr_latch_strobe_o <= 1'b1;
			program_store_strobe_o <= 1'b1;
			resume_o <= 1'b0;
			cycle_en_o <= 1'b0;
		end else begin
			// Fetch halts in idle; RAM and registers are simply not written
			fetch_en_o <= (state_d == psc_pkg::PSC_RUN);
			clk_run_o <= (state_d != psc_pkg::PSC_PDOWN);
			osc_restart_o <= (state_d == psc_pkg::PSC_PDOWN) && wake_en_q && wake_level_q &&
				!ext_int_lvl;
			addr_latch_strobe_o <= (state_d != psc_pkg::PSC_PDOWN);
			program_store_strobe_o <= (state_d != psc_pkg::PSC_PDOWN);
			resume_o <= (state_q != psc_pkg::PSC_RUN) && (state_d == psc_pkg::PSC_RUN);
			cycle_en_o <= cyc_en && (state_d == psc_pkg::PSC_RUN);
		end
	end
endmodule // psc_ctrl

// file: include/psc_defines.svh
// Offsets, field positions, programming key and timing counts of the power/clock-mode block
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// Register indexes; the byte address is four times the index
`define PSC_OFS_FLASH_STATUS 12'h0B6
`define PSC_OFS_POWER_CTRL 12'h087
`define PSC_OFS_WAKE_CFG 12'h0A8
`define PSC_OFS_MODE_STAT 12'h0AC
`define PSC_OFS_PROG_CTRL 12'h0B0
`define PSC_BIT_IDLE 0
`define PSC_BIT_PDOWN 1
`define PSC_BIT_DOUBLE 3
`define PSC_BIT_SECURITY 6
`define PSC_BIT_PROG_KEY_LO 8
`define PSC_PROG_KEY 8'hA5
`define PSC_WAKE_LOW_CYCLES 1024
`define PSC_CYCLES_X1 4'hC
`define PSC_CYCLES_X2 4'h6
`endif

// file: include/psc_pkg.sv
// Types of the power/clock-mode block
package psc_pkg;
	typedef enum logic [3:0] {
		PSC_RUN = 4'h1,
		PSC_IDLE = 4'h2,
		PSC_PDOWN = 4'h4,
		PSC_WAKE = 4'h8
	} psc_state_t;
endpackage

// file: design/psc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module psc_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			level_o <= RESET_VAL;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change counts only once second and third agree
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule // psc_sync

// file: design/psc_cycle_div.sv
// Machine-cycle enable divider, 12 or 6 clocks per cycle
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_cycle_div (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic double_i,
	output logic cycle_en_o
);
	logic [3:0] cnt_q;
	logic [3:0] last;

	assign last = double_i ? (`PSC_CYCLES_X2 - 4'h1) : (`PSC_CYCLES_X1 - 4'h1);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= 4'h0;
			cycle_en_o <= 1'b0;
		end else if (!run_i) begin
			// Stopped clock: no machine cycles at all
			cnt_q <= 4'h0;
			cycle_en_o <= 1'b0;
		end else if (cnt_q >= last) begin
			cnt_q <= 4'h0;
			cycle_en_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			cycle_en_o <= 1'b0;
		end
	end
endmodule // psc_cycle_div

// file: tb/psc_ctrl_chk.sv
// Port checker for the power-saving controller
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_ctrl_chk (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic fetch_en_o,
	input wire logic clk_run_o,
	input wire logic osc_restart_o,
	input wire logic cycle_en_o,
	input wire logic addr_latch_strobe_o,
	input wire logic program_store_strobe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic pc_wr;
	// First access edge only, while running
	assign pc_wr = psel_i && penable_i && !pready_o && pwrite_i && fetch_en_o
		&& paddr_i[11:2] == 10'(`PSC_OFS_POWER_CTRL) && paddr_i[1:0] == 2'b00;
	property p_idle_entry;
		pc_wr && pwdata_i[1:0] == 2'h1 |-> ##[1:3] (!fetch_en_o && clk_run_o);
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
	property p_pd_entry;
		pc_wr && pwdata_i[1] |-> ##[1:3] !clk_run_o;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");
	property p_idle_strobes;
		!fetch_en_o && clk_run_o |-> addr_latch_strobe_o && program_store_strobe_o;
	endproperty
	a_idle_strobes: assert property (p_idle_strobes) else $error("idle strobes");
	property p_pd_strobes;
		!clk_run_o |-> !addr_latch_strobe_o && !program_store_strobe_o;
	endproperty
	a_pd_strobes: assert property (p_pd_strobes) else $error("pd strobes");
	property p_pd_stop;
		!clk_run_o |-> !fetch_en_o && !cycle_en_o;
	endproperty
	a_pd_stop: assert property (p_pd_stop) else $error("activity in pd");
	property p_cycle_run;
		cycle_en_o |-> fetch_en_o;
	endproperty
	a_cycle_run: assert property (p_cycle_run) else $error("cycle outside run");
	property p_cycle_gap;
		cycle_en_o |=> !cycle_en_o [*5];
	endproperty
	a_cycle_gap: assert property (p_cycle_gap) else $error("cycle too short");
	property p_osc;
		osc_restart_o |-> !clk_run_o;
	endproperty
	a_osc: assert property (p_osc) else $error("restart outside pd");
	c_wake: cover property (!clk_run_o ##1 clk_run_o);
	c_osc: cover property (osc_restart_o);
	c_idle: cover property (!fetch_en_o && clk_run_o);
endmodule // psc_ctrl_chk

// file: tb/psc_wake_src.sv
// External wake pin driver, low for a commanded count
`timescale 1ns/1ps
module psc_wake_src (
	input wire logic core_clk_i,
	input wire logic start_i,
	input wire logic [15:0] hold_i,
	output logic ext_int_n_o
);
	logic [15:0] cnt_q = 16'h0000;
	// Pulled up when released
	assign ext_int_n_o = (cnt_q == 16'h0000);
	always_ff @(posedge core_clk_i) begin
		if (start_i) begin
			cnt_q <= hold_i;
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
endmodule // psc_wake_src

// file: tb/tb_top.sv
// Bench for the power-saving controller
`timescale 1ns/1ps
`include "psc_defines.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, svc = 1'b0, ws = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] wh = 16'h0000;
	logic pready, pslverr, err, fetch, crun, osc, cyc, als, pss, pin_n, res;
	int bad_count = 0, tests_run = 0, ticks = 0, resumes = 0;
	// Core clock only; external oscillator rate limits are not modelled
	always #4 clk = ~clk;
	psc_ctrl #(.WAKE_LOW_CYCLES(8)) u_psc_ctrl (.core_clk_i(clk), .sys_rst_i(rst),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ext_int_n_i(pin_n),
		.irq_pending_i(1'b0), .irq_service_start_i(svc), .fetch_en_o(fetch), .clk_run_o(crun),
		.osc_restart_o(osc), .cycle_en_o(cyc), .addr_latch_strobe_o(als),
		.program_store_strobe_o(pss), .resume_o(res));
	psc_wake_src u_psc_wake_src (.core_clk_i(clk), .start_i(ws), .hold_i(wh), .ext_int_n_o(pin_n));
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		ticks++;
		if (res === 1'b1) resumes++;
		if (ticks > 3000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] st();
		return {28'h0, fetch, crun, als, pss};
	endfunction
	// Takes a register index; only the global timeout ends the wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {a[9:0], 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic period(input logic [31:0] exp);
		logic [31:0] n;
		n = 32'h0;
		while (cyc !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		n = 32'h0;
		do begin
			@(posedge clk);
			n++;
		end while (cyc !== 1'b1 && n < 40);
		chk(n, exp);
	endtask
	task automatic pulse_svc();
		svc <= 1'b1;
		@(posedge clk);
		svc <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic wake(input logic [15:0] h);
		ws <= 1'b1;
		wh <= h;
		@(posedge clk);
		ws <= 1'b0;
	endtask
	task automatic t_reset();
		chk(st(), 32'hF);
		period(32'hC);
		apb(1'b0, `PSC_OFS_FLASH_STATUS, 32'h0);
		chk(rd & 32'h8, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("reset test done");
	endtask
	task automatic t_idle();
		apb(1'b1, `PSC_OFS_WAKE_CFG, 32'h3);
		apb(1'b1, `PSC_OFS_POWER_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk(st(), 32'h7);
		apb(1'b0, `PSC_OFS_WAKE_CFG, 32'h0);
		chk(rd, 32'h3);
		pulse_svc();
		chk(st(), 32'hF);
		chk(resumes, 32'h1);
		apb(1'b0, `PSC_OFS_POWER_CTRL, 32'h0);
		chk(rd, 32'h0);
		$display("idle test done");
	endtask
	task automatic t_pd();
		int n;
		n = 0;
		apb(1'b1, `PSC_OFS_POWER_CTRL, 32'h3);
		repeat (3) @(posedge clk);
		chk(st(), 32'h0);
		// Too short a low pulse must not wake
		wake(16'h0003);
		repeat (12) @(posedge clk);
		chk(st(), 32'h0);
		wake(16'h0014);
		repeat (12) @(posedge clk);
		chk({31'h0, osc}, 32'h1);
		while (als !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk(st(), 32'h7);
		pulse_svc();
		chk(st(), 32'hF);
		chk(resumes, 32'h2);
		apb(1'b0, `PSC_OFS_POWER_CTRL, 32'h0);
		chk(rd, 32'h0);
		$display("power-down test done");
	endtask
	task automatic t_mode();
		apb(1'b1, `PSC_OFS_PROG_CTRL, 32'h8);
		apb(1'b0, `PSC_OFS_FLASH_STATUS, 32'h0);
		chk(rd & 32'h8, 32'h0);
		apb(1'b1, `PSC_OFS_PROG_CTRL, 32'hA508);
		apb(1'b1, `PSC_OFS_FLASH_STATUS, 32'h0);
		apb(1'b0, `PSC_OFS_FLASH_STATUS, 32'h0);
		chk(rd & 32'h8, 32'h8);
		period(32'h6);
		$display("mode test done");
	endtask
	task automatic t_rst_pd();
		apb(1'b1, `PSC_OFS_WAKE_CFG, 32'h1);
		apb(1'b1, `PSC_OFS_POWER_CTRL, 32'h2);
		// Edge-type wake config must neither restart nor wake
		wake(16'h0014);
		repeat (12) @(posedge clk);
		chk({31'h0, osc}, 32'h0);
		repeat (20) @(posedge clk);
		chk(st(), 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(st(), 32'hF);
		apb(1'b0, `PSC_OFS_FLASH_STATUS, 32'h0);
		chk(rd & 32'h8, 32'h0);
		$display("reset in power-down test done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_idle();
		t_pd();
		t_mode();
		t_rst_pd();
		results();
	end
endmodule // tb_top
bind psc_ctrl psc_ctrl_chk u_psc_ctrl_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o), .fetch_en_o(fetch_en_o), .clk_run_o(clk_run_o),
	.osc_restart_o(osc_restart_o), .cycle_en_o(cycle_en_o),
	.addr_latch_strobe_o(addr_latch_strobe_o), .program_store_strobe_o(program_store_strobe_o));
